// File: logic/hpcfg_bank.sv
// configuration register bank for pins and device behaviour, axi4-lite slave
// =====================================================
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "hpcfg_regs.svh"
module hpcfg_bank #(
  parameter int unsigned SLEEP_LONG_CYC = `HPCFG_SLP3_MS * 1000 * `HPCFG_CLK_MHZ, // 200ms
  parameter int unsigned SLEEP_MID_CYC  = `HPCFG_SLP2_MS * 1000 * `HPCFG_CLK_MHZ, // 20ms
  parameter int unsigned GAIN_TICK_CYC  = `HPCFG_GAIN_MS * 1000 * `HPCFG_CLK_MHZ  // 1ms
) (
  input  wire logic                  i_core_clk,         // 25 MHz core clock
  input  wire logic                  i_reset,            // sync reset, high
  input  wire logic [11:0]           s_axi_awaddr,       // write address
  input  wire logic                  s_axi_awvalid,      // write address valid
  output logic                       s_axi_awready,      // write address ready
  input  wire logic [31:0]           s_axi_wdata,        // write data
  input  wire logic [3:0]            s_axi_wstrb,        // byte strobes
  input  wire logic                  s_axi_wvalid,       // write data valid
  output logic                       s_axi_wready,       // write data ready
  output logic [1:0]                 s_axi_bresp,        // write response
  output logic                       s_axi_bvalid,       // write response valid
  input  wire logic                  s_axi_bready,       // write response ready
  input  wire logic [11:0]           s_axi_araddr,       // read address
  input  wire logic                  s_axi_arvalid,      // read address valid
  output logic                       s_axi_arready,      // read address ready
  output logic [31:0]                s_axi_rdata,        // read data
  output logic [1:0]                 s_axi_rresp,        // read response
  output logic                       s_axi_rvalid,       // read data valid
  input  wire logic                  s_axi_rready,       // read data ready
  input  wire logic                  i_nv_load,          // stored config load pulse
  input  wire logic [6:0]            i_nv_bus_addr,      // stored target address
  input  wire logic                  i_brake_pin,        // brake pin, async
  input  wire logic                  i_speed_low,        // speed below threshold, async
  input  wire logic [14:0]           i_speed_freq,       // measured speed pin frequency
  input  wire logic                  i_freq_new,         // new frequency sample pulse
  output logic                       o_brake_lowside,    // low-side braking active
  output logic                       o_brake_align,      // align braking active
  output hpcfg_pkg::hpcfg_speed_t    o_speed_format,     // speed pin interpretation
  output logic [9:0]                 o_freq_duty,        // frequency duty, 0.1 percent
  output logic [1:0]                 o_aux2_src,         // 0 dac two, 1..3 phase a..c
  output logic                       o_aux_pair_dac_en,  // pins carry dac one and two
  output logic [1:0]                 o_supply_range,     // 0 15V, 1 30V, 2 60V
  output logic                       o_csa_gain_tick,    // current gain retune pulse
  output logic                       o_volt_gain_tick,   // voltage gain retune pulse
  output logic                       o_sleep_req,        // enter sleep
  output logic                       o_standby_req,      // enter standby
  output hpcfg_pkg::hpcfg_clksrc_t   o_clk_src,          // selected clock source
  output logic                       o_ext_clk_ref_en,   // external reference mode
  output logic [6:0]                 o_bus_addr          // serial target address
);
  import hpcfg_pkg::*;

  // =====================================================
  // registers and derived counts
  localparam int unsigned SLP0_CYC = `HPCFG_SLP0_US * `HPCFG_CLK_MHZ; // 50us
  localparam int unsigned SLP1_CYC = `HPCFG_SLP1_US * `HPCFG_CLK_MHZ; // 200us
  logic [31:0] pin_r;          // pin function settings
  logic [31:0] dev1_r;         // device settings one
  logic [31:0] dev2_r;         // device settings two
  logic [1:0]  brk_sync_r;     // brake pin synchroniser
  logic [1:0]  spd_sync_r;     // speed low synchroniser
  logic        aw_hold_r;      // write address held
  logic        w_hold_r;       // write data held
  logic [11:0] awaddr_r;       // captured write address
  logic [31:0] wdata_r;        // captured write data
  logic [3:0]  wstrb_r;        // captured strobes
  logic [31:0] slp_cnt_r;      // below-threshold time
  logic [31:0] gain_cnt_r;     // 1ms gain timer
  hpcfg_slp_t  slp_st_r;       // low-power state
  logic [31:0] slp_lim;        // selected sleep count
  logic        wr_go;          // both write halves present
  logic [31:0] wmask;          // strobe mask
  logic        brk_on;         // selected brake request

  // =====================================================
  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_r[b]}};
    end
  end

  // capture of write halves
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r[11:2] == 10'(`HPCFG_ADDR_PIN >> 2) ||
                       awaddr_r[11:2] == 10'(`HPCFG_ADDR_DEV1 >> 2) ||
                       awaddr_r[11:2] == 10'(`HPCFG_ADDR_DEV2 >> 2) ||
                       awaddr_r[11:2] == 10'(`HPCFG_ADDR_STAT >> 2)) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register storage; reserved bits stay zero through the masks
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pin_r  <= `HPCFG_PIN_RST;
      dev1_r <= `HPCFG_DEV1_RST;
      dev2_r <= `HPCFG_DEV2_RST;
    end else begin
      if (i_nv_load) begin
        // address comes from stored configuration, not a fixed reset value
        dev1_r[`HPCFG_ADDR_LSB +: 7] <= i_nv_bus_addr;
      end
      if (wr_go && awaddr_r[11:2] == 10'(`HPCFG_ADDR_PIN >> 2)) begin
        pin_r <= (pin_r & ~wmask) | (wdata_r & wmask & `HPCFG_PIN_MASK);
      end
      if (wr_go && awaddr_r[11:2] == 10'(`HPCFG_ADDR_DEV1 >> 2)) begin
        dev1_r <= (dev1_r & ~wmask) | (wdata_r & wmask & `HPCFG_DEV1_MASK);
      end
      if (wr_go && awaddr_r[11:2] == 10'(`HPCFG_ADDR_DEV2 >> 2)) begin
        dev2_r <= (dev2_r & ~wmask) | (wdata_r & wmask & `HPCFG_DEV2_MASK);
      end
    end
  end

  // =====================================================
  // read channel: one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr[11:2])
        10'(`HPCFG_ADDR_PIN >> 2):  s_axi_rdata <= pin_r;
        10'(`HPCFG_ADDR_DEV1 >> 2): s_axi_rdata <= dev1_r;
        10'(`HPCFG_ADDR_DEV2 >> 2): s_axi_rdata <= dev2_r;
        // live status: sleep state, synced pins, duty
        10'(`HPCFG_ADDR_STAT >> 2): s_axi_rdata <= {16'h0000, o_freq_duty, o_standby_req,
                                                    o_sleep_req, brk_sync_r[1],
                                                    spd_sync_r[1], 2'h0};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================
  // pin synchronisers
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      brk_sync_r <= 2'b00;
      spd_sync_r <= 2'b00;
    end else begin
      brk_sync_r <= {brk_sync_r[0], i_brake_pin};
      spd_sync_r <= {spd_sync_r[0], i_speed_low};
    end
  end

  // =====================================================
  // brake source select; codes 0 and 3 follow the synced pin
  always_comb begin
    case (hpcfg_brake_t'(pin_r[`HPCFG_BRAKE_LSB +: 2]))
      HPCFG_BRK_FORCE: brk_on = 1'b1;
      HPCFG_BRK_NEVER: brk_on = 1'b0;
      default:         brk_on = brk_sync_r[1]; // codes 0 and 3
    endcase
  end

  // brake kind, registered outputs
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_brake_lowside <= 1'b0;
      o_brake_align   <= 1'b0;
    end else begin
      o_brake_align   <= brk_on && pin_r[`HPCFG_BRK_MODE_BIT];
      o_brake_lowside <= brk_on && !pin_r[`HPCFG_BRK_MODE_BIT];
    end
  end

  // =====================================================
  // configuration fields straight to the datapath
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_speed_format    <= HPCFG_SPD_ANALOG;
      o_aux2_src        <= 2'h0;
      o_aux_pair_dac_en <= 1'b0;
      o_supply_range    <= 2'h0;
      o_clk_src         <= HPCFG_CLK_INT;
      o_ext_clk_ref_en  <= 1'b0;
      o_bus_addr        <= 7'h00;
    end else begin
      o_speed_format    <= hpcfg_speed_t'(pin_r[`HPCFG_SPEED_LSB +: 2]);
      o_aux2_src        <= dev1_r[`HPCFG_PIN38_LSB +: 2];
      o_aux_pair_dac_en <= dev1_r[`HPCFG_PIN3637_BIT];
      o_supply_range    <= dev1_r[`HPCFG_VOLT_LSB +: 2];
      // reserved clock code 2 would be undefined; hold internal instead
      o_clk_src         <= (dev2_r[`HPCFG_CLK_LSB +: 2] == 2'h2) ? HPCFG_CLK_INT
                           : hpcfg_clksrc_t'(dev2_r[`HPCFG_CLK_LSB +: 2]);
      o_ext_clk_ref_en  <= dev2_r[`HPCFG_EXTCLK_BIT];
      o_bus_addr        <= dev1_r[`HPCFG_ADDR_LSB +: 7];
    end
  end

  // =====================================================
  // frequency duty, only in frequency mode
  hpcfg_freq_div #(.W(15)) u_div (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_start    (i_freq_new && o_speed_format == HPCFG_SPD_FREQ),
    .i_num      (i_speed_freq),
    .i_den      (dev2_r[`HPCFG_FREQ_LSB +: 15]),
    .o_quot     (o_freq_duty),
    .o_done     ()
  );

  // =====================================================
  // 1ms gain retune tick shared by both gains
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      gain_cnt_r       <= 32'h00000000;
      o_csa_gain_tick  <= 1'b0;
      o_volt_gain_tick <= 1'b0;
    end else begin
      if (gain_cnt_r >= GAIN_TICK_CYC - 1) begin
        gain_cnt_r <= 32'h00000000;
      end else begin
        gain_cnt_r <= gain_cnt_r + 32'h1;
      end
      o_csa_gain_tick  <= (gain_cnt_r == GAIN_TICK_CYC - 1) && dev2_r[`HPCFG_CSA_BIT];
      o_volt_gain_tick <= (gain_cnt_r == GAIN_TICK_CYC - 1) && dev2_r[`HPCFG_VGAIN_BIT];
    end
  end

  // =====================================================
  // sleep entry timer and low-power state
  always_comb begin
    case (dev2_r[`HPCFG_SLEEP_LSB +: 2])
      2'h0:    slp_lim = SLP0_CYC;
      2'h1:    slp_lim = SLP1_CYC;
      2'h2:    slp_lim = SLEEP_MID_CYC;
      default: slp_lim = SLEEP_LONG_CYC;
    endcase
  end

  // any return above threshold restarts the wait: time must be continuous
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      slp_cnt_r <= 32'h00000000;
      slp_st_r  <= HPCFG_SL_RUN;
    end else begin
      case (slp_st_r)
        HPCFG_SL_RUN: begin
          slp_cnt_r <= 32'h00000000;
          if (spd_sync_r[1]) slp_st_r <= HPCFG_SL_WAIT;
        end
        HPCFG_SL_WAIT: begin
          if (!spd_sync_r[1]) begin
            slp_st_r <= HPCFG_SL_RUN;
          end else if (slp_cnt_r >= slp_lim - 1) begin
            slp_st_r <= dev2_r[`HPCFG_LPM_BIT] ? HPCFG_SL_SLEEP : HPCFG_SL_STBY;
          end else begin
            slp_cnt_r <= slp_cnt_r + 32'h1;
          end
        end
        HPCFG_SL_SLEEP, HPCFG_SL_STBY: begin
          if (!spd_sync_r[1]) slp_st_r <= HPCFG_SL_RUN;
        end
        default: slp_st_r <= HPCFG_SL_RUN;
      endcase
    end
  end
  assign o_sleep_req   = (slp_st_r == HPCFG_SL_SLEEP);
  assign o_standby_req = (slp_st_r == HPCFG_SL_STBY);

  // =====================================================
  // checks
  a_brake_never: assert property (@(posedge i_core_clk) disable iff (i_reset)
    pin_r[3:2] == 2'h2 && $stable(pin_r) |=> !o_brake_lowside && !o_brake_align)
    else $error("brake active while override says never");
  a_brake_force: assert property (@(posedge i_core_clk) disable iff (i_reset)
    pin_r[3:2] == 2'h1 && $stable(pin_r) |=>
    (o_brake_align == $past(pin_r[5])) && (o_brake_lowside != $past(pin_r[5])))
    else $error("forced brake kind wrong");
  a_speed_fmt: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $stable(pin_r) |=> o_speed_format == $past(pin_r[1:0]))
    else $error("speed format mismatch");
  a_aux_route: assert property (@(posedge i_core_clk) disable iff (i_reset)
    1'b1 |=> o_aux2_src == $past(dev1_r[29:28]) && o_aux_pair_dac_en == $past(dev1_r[27]))
    else $error("aux routing mismatch");
  a_supply_range: assert property (@(posedge i_core_clk) disable iff (i_reset)
    1'b1 |=> o_supply_range == $past(dev1_r[1:0]))
    else $error("supply range mismatch");
  a_gain_tick: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_csa_gain_tick |=> !o_csa_gain_tick [*8])
    else $error("current gain tick too frequent");
  a_sleep_fast: assert property (@(posedge i_core_clk) disable iff (i_reset)
    slp_st_r == HPCFG_SL_WAIT && spd_sync_r[1] && slp_cnt_r < slp_lim - 32'h1
    |=> slp_st_r == HPCFG_SL_WAIT)
    else $error("sleep wait left before its time");
  a_sleep_kind: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(o_sleep_req) |-> $past(dev2_r[11]))
    else $error("sleep entered with standby selected");
  a_clk_sel: assert property (@(posedge i_core_clk) disable iff (i_reset)
    1'b1 |=> o_ext_clk_ref_en == $past(dev2_r[8]) && o_clk_src != HPCFG_CLK_RSVD)
    else $error("clock selection mismatch");
  c_sleep: cover property (@(posedge i_core_clk) $rose(o_sleep_req));
  c_standby: cover property (@(posedge i_core_clk) $rose(o_standby_req));
  c_align: cover property (@(posedge i_core_clk) o_brake_align);
endmodule : hpcfg_bank

// File: logic/hpcfg_freq_div.sv
// sequential divider: measured frequency over full-scale, result in permille
`timescale 1ns/1ps
module hpcfg_freq_div #(
  parameter int unsigned W = 15   // operand width
) (
  input  wire logic         i_core_clk, // core clock
  input  wire logic         i_reset,    // sync reset, high
  input  wire logic         i_start,    // start pulse
  input  wire logic [W-1:0] i_num,      // measured frequency
  input  wire logic [W-1:0] i_den,      // full-scale frequency
  output logic      [9:0]   o_quot,     // duty in 0.1 percent, clamped
  output logic              o_done      // result valid pulse
);
  logic [W+9:0] rem_r;  // scaled numerator
  logic [W+9:0] acc_r;  // quotient accumulator
  logic [W+9:0] den_r;  // held divisor
  logic         busy_r; // division in progress

  // =====================================================
  // repeated subtraction; slow but small, inputs change slowly
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rem_r  <= '0;
      acc_r  <= '0;
      den_r  <= '0;
      busy_r <= 1'b0;
      o_done <= 1'b0;
      o_quot <= 10'h000;
    end else begin
      o_done <= 1'b0;
      if (i_start && !busy_r) begin
        rem_r  <= (W+10)'(i_num) * (W+10)'(1000);
        den_r  <= (W+10)'(i_den);
        acc_r  <= '0;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        // zero divisor or quotient past full scale ends at 100 percent
        if (den_r == '0 || acc_r >= (W+10)'(1000)) begin
          o_quot <= 10'h3e8;
          busy_r <= 1'b0;
          o_done <= 1'b1;
        end else if (rem_r >= den_r) begin
          rem_r <= rem_r - den_r;
          acc_r <= acc_r + 1'b1;
        end else begin
          o_quot <= acc_r[9:0];
          busy_r <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule : hpcfg_freq_div

// File: pkg/hpcfg_pkg.sv
// types for the hardware pin and device configuration bank
package hpcfg_pkg;
  typedef enum logic [1:0] {HPCFG_BRK_PIN = 2'h0, HPCFG_BRK_FORCE = 2'h1,
                            HPCFG_BRK_NEVER = 2'h2, HPCFG_BRK_PIN2 = 2'h3} hpcfg_brake_t;
  typedef enum logic [1:0] {HPCFG_SPD_ANALOG = 2'h0, HPCFG_SPD_PWM = 2'h1,
                            HPCFG_SPD_UNDEF = 2'h2, HPCFG_SPD_FREQ = 2'h3} hpcfg_speed_t;
  typedef enum logic [1:0] {HPCFG_CLK_INT = 2'h0, HPCFG_CLK_WDT = 2'h1,
                            HPCFG_CLK_RSVD = 2'h2, HPCFG_CLK_EXT = 2'h3} hpcfg_clksrc_t;
  typedef enum logic [3:0] {HPCFG_SL_RUN = 4'b0001, HPCFG_SL_WAIT = 4'b0010,
                            HPCFG_SL_SLEEP = 4'b0100, HPCFG_SL_STBY = 4'b1000} hpcfg_slp_t;
endpackage : hpcfg_pkg

// File: pkg/hpcfg_regs.svh
// register offsets, field positions, reset values and timing figures
`ifndef HPCFG_REGS_SVH
`define HPCFG_REGS_SVH
// register indices; each byte address is its index times four
`define HPCFG_IDX_PIN        8'ha4
`define HPCFG_IDX_DEV1       8'ha6
`define HPCFG_IDX_DEV2       8'ha8
`define HPCFG_ADDR_PIN       12'h290
`define HPCFG_ADDR_DEV1      12'h298
`define HPCFG_ADDR_DEV2      12'h2a0
`define HPCFG_ADDR_STAT      12'h2a4
// field positions
`define HPCFG_BRAKE_LSB      2
`define HPCFG_BRK_MODE_BIT   5
`define HPCFG_SPEED_LSB      0
`define HPCFG_PIN38_LSB      28
`define HPCFG_PIN3637_BIT    27
`define HPCFG_ADDR_LSB       20
`define HPCFG_VOLT_LSB       0
`define HPCFG_FREQ_LSB       16
`define HPCFG_SLEEP_LSB      14
`define HPCFG_CSA_BIT        13
`define HPCFG_VGAIN_BIT      12
`define HPCFG_LPM_BIT        11
`define HPCFG_CLK_LSB        9
`define HPCFG_EXTCLK_BIT     8
// writable masks and reset values
`define HPCFG_PIN_MASK       32'h0000003f
`define HPCFG_DEV1_MASK      32'h3ff00003
`define HPCFG_DEV2_MASK      32'h7fffff00
`define HPCFG_PIN_RST        32'h00000000
`define HPCFG_DEV1_RST       32'h00000000
`define HPCFG_DEV2_RST       32'h00000000
// timing figures
`define HPCFG_CLK_MHZ        25
`define HPCFG_SLP0_US        50
`define HPCFG_SLP1_US        200
`define HPCFG_SLP2_MS        20
`define HPCFG_SLP3_MS        200
`define HPCFG_GAIN_MS        1
`endif

// File: test/tb.sv
// self-checking bench for the pin and device configuration bank
`timescale 1ns/1ps
`include "hpcfg_regs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb;
  import hpcfg_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic i_core_clk = 0, i_reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, awready, wready, bvalid, arready, rvalid, nv_load = 0, brake_pin = 0;
  logic speed_low = 0, freq_new = 0, lowside, align, pair_en, csa_tk, vg_tk, slp, stby, ext;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd, rv;
  logic [1:0]  bresp, rresp, aux2, rng, rs;
  logic [14:0] sfreq = 0;
  logic [9:0]  duty;
  logic [6:0]  nv_addr = 0, baddr;
  hpcfg_speed_t spd;
  hpcfg_clksrc_t clks;
  int n_mismatch = 0, tests_run = 0, seed = 62562, k, c;
  hpcfg_bank #(.SLEEP_LONG_CYC(40), .SLEEP_MID_CYC(20), .GAIN_TICK_CYC(10)) dut_u (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .i_nv_load(nv_load), .i_nv_bus_addr(nv_addr),
    .i_brake_pin(brake_pin), .i_speed_low(speed_low), .i_speed_freq(sfreq),
    .i_freq_new(freq_new), .o_brake_lowside(lowside), .o_brake_align(align),
    .o_speed_format(spd), .o_freq_duty(duty), .o_aux2_src(aux2),
    .o_aux_pair_dac_en(pair_en), .o_supply_range(rng), .o_csa_gain_tick(csa_tk),
    .o_volt_gain_tick(vg_tk), .o_sleep_req(slp), .o_standby_req(stby),
    .o_clk_src(clks), .o_ext_clk_ref_en(ext), .o_bus_addr(baddr));
  // ==========================================
  // clock and watchdog (whole run is a few thousand cycles)
  initial begin
    forever #20 i_core_clk = ~i_core_clk;
  end
  initial begin
    #(40 * 40000);
    n_mismatch++;
    close_out();
  end
  // ==========================================
  // axi4-lite master: hold each channel until its own handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge i_core_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    rs = bresp;
    bready <= 0;
    @(posedge i_core_clk);
  endtask : wr
  task automatic rdreg(input logic [11:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge i_core_clk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rd = rdata; rs = rresp;
    rready <= 0;
    @(posedge i_core_clk);
  endtask : rdreg
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc
  function automatic logic [9:0] exp_duty(input int f, input int fs);
    return (fs == 0) ? 10'd1000 : 10'((f * 1000) / fs); // full scale means 100 percent
  endfunction : exp_duty
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // ==========================================
  // main sequence
  logic [11:0] adr [3] = '{`HPCFG_ADDR_PIN, `HPCFG_ADDR_DEV1, `HPCFG_ADDR_DEV2};
  logic [31:0] msk [3] = '{`HPCFG_PIN_MASK, `HPCFG_DEV1_MASK, `HPCFG_DEV2_MASK};
  // random words keep undefined speed, range and clock codes out
  logic [31:0] fix [3] = '{32'hfffffffd, 32'hfffffffd, 32'hfffffbff};
  initial begin
    cyc(2);
    i_reset <= 0;
    @(posedge i_core_clk);
    for (k = 0; k < 3; k++) begin
      rdreg(adr[k]); `CHK("reset value", 32'h0, rd)
    end
    rdreg(12'h2c0); `CHK("unmapped read", 2'h2, rs)
    wr(12'h2c0, 32'h1); `CHK("unmapped write", 2'h2, rs)
    for (k = 0; k < 9; k++) begin // random data, reserved bits read zero
      rv = $random(seed) & fix[k % 3];
      wr(adr[k % 3], rv); `CHK("write resp", 2'h0, rs)
      rdreg(adr[k % 3]); `CHK("readback", rv & msk[k % 3], rd)
    end
    $display("test registers done");
    for (c = 0; c < 4; c++) begin // every defined code of the two-bit fields
      k = (c == 2) ? 1 : c; // no undefined speed or clock code
      wr(`HPCFG_ADDR_PIN, 32'(k));
      wr(`HPCFG_ADDR_DEV1, (32'(c) << 28) | (32'(c & 1) << 27) | 32'((c == 3) ? 2 : c));
      wr(`HPCFG_ADDR_DEV2, (32'(k) << 9) | (32'(c & 1) << 8));
      cyc(2);
      `CHK("speed fmt", 2'(k), spd)
      `CHK("aux2 src", 2'(c), aux2)
      `CHK("pair dac", 1'(c & 1), pair_en)
      `CHK("range", 2'((c == 3) ? 2 : c), rng)
      `CHK("clk src", 2'(k), clks)
      `CHK("ext ref", 1'(c & 1), ext)
    end
    $display("test field codes done");
    for (k = 0; k < 16; k++) begin // code, behaviour bit, pin level
      brake_pin <= k[0];
      wr(`HPCFG_ADDR_PIN, (32'(k[3:2]) << 2) | (32'(k[1]) << 5));
      cyc(5);
      c = (k[3:2] == 2'h1) ? 1 : (k[3:2] == 2'h2) ? 0 : k[0];
      `CHK("brake low", 1'(c & ~k[1]), lowside)
      `CHK("brake align", 1'(c & k[1]), align)
    end
    $display("test brake done");
    nv_load <= 1; nv_addr <= 7'h5a;
    @(posedge i_core_clk);
    nv_load <= 0;
    cyc(2); `CHK("bus addr", 7'h5a, baddr)
    rdreg(`HPCFG_ADDR_DEV1); `CHK("addr field", 7'h5a, rd[26:20])
    $display("test address done");
    for (k = 0; k < 3; k++) begin // csa only, voltage only, neither
      wr(`HPCFG_ADDR_DEV2, (k == 0) ? 32'h2000 : (k == 1) ? 32'h1000 : 32'h0);
      cyc(3); c = 0; tests_run++;
      repeat (100) begin
        @(posedge i_core_clk);
        c += int'(csa_tk) + 256 * int'(vg_tk);
      end
      `CHK("tick count", (k == 0) ? 10 : (k == 1) ? 2560 : 0, c)
    end
    $display("test gain ticks done");
    for (k = 1; k >= 0; k--) begin // sleep select then standby, delay code 3
      wr(`HPCFG_ADDR_DEV2, 32'hc000 | (32'(k) << 11));
      speed_low <= 1;
      cyc(30); `CHK("early", 1'b0, slp | stby)
      cyc(30); `CHK("sleep", 1'(k), slp)
      `CHK("standby", 1'(1 - k), stby)
      rdreg(`HPCFG_ADDR_STAT); `CHK("stat sleep", (k == 1) ? 2'h1 : 2'h2, rd[5:4])
      speed_low <= 0;
      cyc(10); `CHK("wake", 1'b0, slp | stby)
    end
    $display("test sleep done");
    wr(`HPCFG_ADDR_PIN, 32'h3);
    for (k = 0; k < 3; k++) begin
      c = 100 + ($random(seed) & 16'h3ff);
      sfreq <= 15'(c * k / 2);
      wr(`HPCFG_ADDR_DEV2, 32'(c) << 16);
      freq_new <= 1;
      @(posedge i_core_clk);
      freq_new <= 0;
      for (int w = 0; w < 2000 && duty !== exp_duty(c * k / 2, c); w++) cyc(1);
      `CHK("duty", exp_duty(c * k / 2, c), duty)
    end
    $display("test duty done");
    close_out();
  end
endmodule : tb
